// File: include/cio_pkg.sv
// Shared constants and carrier types for the configurable I/O port block
package cio_pkg;
  localparam int NPORT = 4;
  localparam int PW = 8;
  localparam logic [1:0] PORT_A = 2'h0;
  localparam logic [1:0] PORT_B = 2'h1;
  localparam logic [1:0] PORT_C = 2'h2;
  localparam logic [1:0] PORT_D = 2'h3;
  // Register select codes on the write port
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_DIR = 2'h1;
  localparam logic [1:0] SEL_DOUT = 2'h2;
  localparam logic [7:0] REG_RST = 8'h00;
  // Peripheral mode enable bit in the memory map control register
  localparam int PIO_BIT = 7;
  // Pins present per port
  localparam logic [7:0] FULL_MASK = 8'hFF;
  localparam logic [7:0] C_USE_MASK = 8'h9C;
  localparam logic [7:0] C_TEST_MASK = 8'h63;
  localparam logic [7:0] D_MASK = 8'h07;
  localparam logic [7:0] D_ECS_MASK = 8'h06;
  // Input cell modes
  localparam logic [1:0] IC_PASS = 2'h0;
  localparam logic [1:0] IC_LATCH = 2'h1;
  localparam logic [1:0] IC_EDGE = 2'h2;
  typedef enum logic [2:0] {
    RB_DIN = 3'b000,
    RB_DOUT = 3'b001,
    RB_DIR = 3'b010,
    RB_CTRL = 3'b011,
    RB_CELL = 3'b100,
    RB_INCELL = 3'b101,
    RB_ENABLE = 3'b110
  } cio_rb_t;
  typedef struct packed {
    logic we;
    logic [1:0] port;
    logic [1:0] sel;
    logic [7:0] data;
  } cio_wr_t;
  typedef struct packed {
    logic [1:0] port;
    cio_rb_t src;
  } cio_rd_t;
  typedef struct packed {
    logic [7:0] addr;
    logic ale;
    logic [7:0] data;
    logic wr;
    logic [7:0] memMap;
  } cio_mcu_t;
  typedef struct packed {
    logic [7:0] grp1;
    logic [7:0] grp2;
    logic [3:0][7:0] oePt;
    logic [1:0] ecs;
    logic pselA;
    logic pselB;
    logic [5:0] icPt;
  } cio_arr_t;
endpackage

// File: hdl/cio_ports.sv
// Four configurable I/O ports: output mux, driver enables, input cells, readback
`timescale 1ns/100ps
//
// Contract
// - Four ports: A, B, C eight pins, D three pins, each pin separately set.
// - Pin output muxes data-out, latched address, output cell, or extra chip select.
// - Readback places exactly one selected source on the read data per read.
// - Driver enable is enable product term OR direction bit.
// - Without enable term or logic output, direction bit alone enables driver.
// - Ports A, B, C input cells: latch, edge register or pass, strobe or term.
// - Input cell outputs feed logic array and are readable by the MCU.
// - Logic and data port modes fixed by parameters; peripheral mode from memory map bit seven; others writable.
// - Control bit zero selects MCU I/O; direction from bit or enable term.
// - MCU I/O output drives data-out; input pin readable through data-in.
// - Ports C and D lack control register; MCU I/O unless logic assigned.
// - Logic output tri-stated when enable term inactive and direction bit zero.
// - A/B address out only with enable term, or direction and control both set.
// - Pins 3..0 carry address 3..0, pins 7..4 carry address 7..4.
// - Memory map control bit seven makes port A a bidirectional data buffer.
// - Peripheral buffer drives only while a peripheral select is active.
// - Mode availability per port; C second group on four pins; D chip selects.
// - Direction, control and data-out registers read back.
// - Direction one means output; all pins input after reset.
// - Control and direction registers reset to zero.
// - Enable status per port reports each pin's driver enable.
module cio_ports #(
  parameter logic [3:0][7:0] LOGIC_OUT = '0,
  parameter logic [3:0][7:0] OE_PT_DEF = '0,
  parameter logic [7:0] B_GRP2 = 8'h00,
  parameter logic [11:0] IC_MODE = 12'h000,
  parameter logic [5:0] IC_USE_PT = 6'h00
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire cio_pkg::cio_wr_t regWr,
  input wire cio_pkg::cio_rd_t rdReq,
  input wire cio_pkg::cio_mcu_t mcu,
  input wire cio_pkg::cio_arr_t arr,
  input wire logic [3:0][7:0] pinIn,
  output logic [3:0][7:0] pinOut,
  output logic [3:0][7:0] pinOe,
  output logic [7:0] readData,
  output logic [7:0] periphRdData,
  output logic [2:0][7:0] inputCellOut
);
  import cio_pkg::*;

  localparam logic [3:0][7:0] VALID = {D_MASK, C_USE_MASK, FULL_MASK, FULL_MASK};

  // Configuration checks
  if ((LOGIC_OUT[2] & ~C_USE_MASK) != 8'h00)
  begin : g_chkC
    $error("port C logic outputs only on pins 2,3,4,7");
  end
  if ((LOGIC_OUT[3] & ~D_ECS_MASK) != 8'h00)
  begin : g_chkD
    $error("port D logic outputs only chip selects on pins 1,2");
  end

  logic rstnMeta;
  logic rstnQ;
  logic [3:0][7:0] pinMeta;
  logic [3:0][7:0] pinSync;
  logic [1:0][7:0] ctrl_reg;
  logic [3:0][7:0] dir_reg;
  logic [3:0][7:0] dout_reg;
  logic [3:0][7:0] pinOut_reg;
  logic [3:0][7:0] pinOe_reg;
  logic [3:0][7:0] outNext;
  logic [3:0][7:0] oeNext;
  logic [3:0][7:0] cellVal;
  logic [2:0][7:0] ic_reg;
  logic [2:0][7:0] icEnPrev;
  logic [7:0] readData_reg;
  logic [7:0] readData_next;
  logic [7:0] periph_reg;
  logic periph_io_enable_bit;
  logic psel;

  assign pinOut = pinOut_reg;
  assign pinOe = pinOe_reg;
  assign readData = readData_reg;
  assign periphRdData = periph_reg;
  assign inputCellOut = ic_reg;
  assign periph_io_enable_bit = mcu.memMap[PIO_BIT];
  assign psel = arr.pselA | arr.pselB;

  // Reset release through two flops
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rstnMeta <= 1'b0;
      rstnQ <= 1'b0;
    end
    else
    begin
      rstnMeta <= 1'b1;
      rstnQ <= rstnMeta;
    end
  end

  // Pin input synchroniser
  always_ff @(posedge ref_clk or negedge rstnQ)
  begin
    if (!rstnQ)
    begin
      pinMeta <= '0;
      pinSync <= '0;
    end
    else
    begin
      pinMeta <= pinIn;
      pinSync <= pinMeta;
    end
  end

  // Run-time writable registers; C and D have no control register
  always_ff @(posedge ref_clk or negedge rstnQ)
  begin
    if (!rstnQ)
    begin
      ctrl_reg <= {REG_RST, REG_RST};
      dir_reg <= {4{REG_RST}};
      dout_reg <= {4{REG_RST}};
    end
    else if (regWr.we)
    begin
      case (regWr.sel)
        SEL_CTRL:
        begin
          if (!regWr.port[1])
          begin
            ctrl_reg[regWr.port[0]] <= regWr.data;
          end
        end
        SEL_DIR: dir_reg[regWr.port] <= regWr.data & VALID[regWr.port];
        SEL_DOUT: dout_reg[regWr.port] <= regWr.data & VALID[regWr.port];
        default: ;
      endcase
    end
  end

  // Per pin output source and driver enable
  for (genvar p = 0; p < NPORT; p++)
  begin : g_port
    for (genvar i = 0; i < PW; i++)
    begin : g_pin
      logic ctl;
      logic oeTerm;
      assign ctl = (p < 2) ? ctrl_reg[p % 2][i] : 1'b0;
      assign oeTerm = arr.oePt[p][i] & OE_PT_DEF[p][i];
      // Output cell feeding this pin
      always_comb
      begin
        case (p)
          0: cellVal[p][i] = arr.grp1[i];
          1: cellVal[p][i] = B_GRP2[i] ? arr.grp2[i] : arr.grp1[i];
          2: cellVal[p][i] = arr.grp2[i] & C_USE_MASK[i];
          default: cellVal[p][i] = (i > 0 && i < 3) ? arr.ecs[(i + 1) % 2] : 1'b0;
        endcase
      end
      // Output mux and enable
      always_comb
      begin
        if (!VALID[p][i] || (p == 2 && C_TEST_MASK[i]))
        begin
          outNext[p][i] = 1'b0;
          oeNext[p][i] = 1'b0;
        end
        else if (p == 0 && periph_io_enable_bit)
        begin
          outNext[p][i] = mcu.data[i];
          oeNext[p][i] = psel & mcu.wr;
        end
        else
        begin
          if (LOGIC_OUT[p][i])
          begin
            outNext[p][i] = cellVal[p][i];
          end
          else if (ctl)
          begin
            outNext[p][i] = mcu.addr[i];
          end
          else
          begin
            outNext[p][i] = dout_reg[p][i];
          end
          oeNext[p][i] = oeTerm | dir_reg[p][i];
        end
      end
      // Pins registered from the settled registers
      always_ff @(posedge ref_clk or negedge rstnQ)
      begin
        if (!rstnQ)
        begin
          pinOut_reg[p][i] <= 1'b0;
          pinOe_reg[p][i] <= 1'b0;
        end
        else
        begin
          pinOut_reg[p][i] <= outNext[p][i];
          pinOe_reg[p][i] <= oeNext[p][i];
        end
      end
    end
  end

  // Input cells on ports A, B and the four free C pins
  for (genvar p = 0; p < 3; p++)
  begin : g_icPort
    for (genvar i = 0; i < PW; i++)
    begin : g_ic
      localparam int N = p * 2 + i / 4;
      logic en;
      assign en = IC_USE_PT[N] ? arr.icPt[N] : mcu.ale;
      always_ff @(posedge ref_clk or negedge rstnQ)
      begin
        if (!rstnQ)
        begin
          ic_reg[p][i] <= 1'b0;
          icEnPrev[p][i] <= 1'b0;
        end
        else
        begin
          icEnPrev[p][i] <= en;
          if (VALID[p][i])
          begin
            case (IC_MODE[2 * N +: 2])
              IC_LATCH: ic_reg[p][i] <= en ? pinSync[p][i] : ic_reg[p][i];
              IC_EDGE: ic_reg[p][i] <= (en && !icEnPrev[p][i]) ? pinSync[p][i] :
                ic_reg[p][i];
              default: ic_reg[p][i] <= pinSync[p][i];
            endcase
          end
        end
      end
      // Latch and edge cells hold while their strobe is low
      property p_cellHold;
        @(posedge ref_clk) disable iff (!rstnQ)
          !en && IC_MODE[2 * N +: 2] != IC_PASS |=> $stable(ic_reg[p][i]);
      endproperty
      a_cellHold: assert property (p_cellHold) else $error("input cell moved");
    end
  end

  // Readback buffer, one source per read
  always_comb
  begin
    case (rdReq.src)
      RB_DIN: readData_next = pinSync[rdReq.port];
      RB_DOUT: readData_next = dout_reg[rdReq.port];
      RB_DIR: readData_next = dir_reg[rdReq.port];
      RB_CTRL: readData_next = rdReq.port[1] ? 8'h00 : ctrl_reg[rdReq.port[0]];
      RB_CELL: readData_next = cellVal[rdReq.port] & VALID[rdReq.port];
      RB_INCELL: readData_next = rdReq.port == PORT_D ? 8'h00 : ic_reg[rdReq.port];
      RB_ENABLE: readData_next = pinOe_reg[rdReq.port];
      default: readData_next = 8'h00;
    endcase
  end

  // Readback and peripheral read data registers
  always_ff @(posedge ref_clk or negedge rstnQ)
  begin
    if (!rstnQ)
    begin
      readData_reg <= 8'h00;
      periph_reg <= 8'h00;
    end
    else
    begin
      readData_reg <= readData_next;
      periph_reg <= pinSync[PORT_A];
    end
  end

  // Checks
  sequence s_dirWrD;
    regWr.we && regWr.sel == SEL_DIR && regWr.port == PORT_D;
  endsequence
  property p_wrEffect;
    @(posedge ref_clk) disable iff (!rstnQ)
      s_dirWrD ##1 !regWr.we |=> pinOe[3] == ((dir_reg[3] | ($past(arr.oePt[3]) & OE_PT_DEF[3]))
        & D_MASK);
  endproperty
  a_wrEffect: assert property (p_wrEffect) else $error("dir write not on pins");
  property p_oeOr;
    @(posedge ref_clk) disable iff (!rstnQ)
      1'b1 |=> pinOe[1] == $past(dir_reg[1] | (arr.oePt[1] & OE_PT_DEF[1]));
  endproperty
  a_oeOr: assert property (p_oeOr) else $error("port B enable wrong");
  property p_doutC;
    @(posedge ref_clk) disable iff (!rstnQ)
      1'b1 |=> ((pinOut[2] ^ $past(dout_reg[2])) & ~LOGIC_OUT[2] & ~C_TEST_MASK) == 8'h00;
  endproperty
  a_doutC: assert property (p_doutC) else $error("port C data out wrong");
  property p_addrOut;
    @(posedge ref_clk) disable iff (!rstnQ)
      !periph_io_enable_bit |=> ((pinOut[1] ^ $past(mcu.addr)) & $past(ctrl_reg[1]) & ~LOGIC_OUT[1]) == 8'h00;
  endproperty
  a_addrOut: assert property (p_addrOut) else $error("address out wrong");
  property p_pioOff;
    @(posedge ref_clk) disable iff (!rstnQ)
      periph_io_enable_bit && !psel |=> pinOe[0] == 8'h00;
  endproperty
  a_pioOff: assert property (p_pioOff) else $error("peripheral buffer drives");
  property p_testPins;
    @(posedge ref_clk) disable iff (!rstnQ)
      (pinOe[2] & C_TEST_MASK) == 8'h00;
  endproperty
  a_testPins: assert property (p_testPins) else $error("test pin driven");
  property p_resetClear;
    @(posedge ref_clk) disable iff (!resetn)
      $rose(rstnQ) |-> dir_reg == '0 && ctrl_reg == '0 ##1 pinOe == '0;
  endproperty
  a_resetClear: assert property (p_resetClear) else $error("not cleared at reset");
  property p_rbDir;
    @(posedge ref_clk) disable iff (!rstnQ)
      rdReq.src == RB_DIR |=> readData == $past(dir_reg[rdReq.port]);
  endproperty
  a_rbDir: assert property (p_rbDir) else $error("direction readback wrong");
  sequence s_pioWrite;
    periph_io_enable_bit && psel && mcu.wr;
  endsequence
  property p_pioDrive;
    @(posedge ref_clk) disable iff (!rstnQ)
      s_pioWrite |=> pinOe[0] == 8'hFF && pinOut[0] == $past(mcu.data);
  endproperty
  a_pioDrive: assert property (p_pioDrive) else $error("peripheral buffer idle");
  property p_cellOut;
    @(posedge ref_clk) disable iff (!rstnQ)
      !periph_io_enable_bit |=> ((pinOut[0] ^ $past(arr.grp1)) & LOGIC_OUT[0]) == 8'h00;
  endproperty
  a_cellOut: assert property (p_cellOut) else $error("output cell not on pin");
  property p_chipSel;
    @(posedge ref_clk) disable iff (!rstnQ)
      1'b1 |=> ((pinOut[3][2:1] ^ $past(arr.ecs)) & LOGIC_OUT[3][2:1]) == 2'h0;
  endproperty
  a_chipSel: assert property (p_chipSel) else $error("chip select not on pin");
endmodule

// File: verification/cio_pin_model.sv
// External pad model: resolves every pin from the block driver and an outside source
`timescale 1ns/100ps
module cio_pin_model (
  input wire logic [3:0][7:0] pinOut,
  input wire logic [3:0][7:0] pinOe,
  input wire logic [3:0][7:0] extDrive,
  output logic [3:0][7:0] pinIn
);
  // Block driver wins where enabled, else the outside device sets the level
  assign pinIn = (pinOe & pinOut) | (~pinOe & extDrive);
endmodule

// File: verification/cio_ports_tb.sv
// Self-checking bench for the configurable I/O port block
`timescale 1ns/100ps
module cio_ports_tb;
  import cio_pkg::*;
  logic ref_clk;
  logic resetn;
  cio_wr_t regWr;
  cio_rd_t rdReq;
  cio_mcu_t mcu;
  cio_arr_t arr;
  logic [3:0][7:0] pinIn;
  logic [3:0][7:0] pinOut;
  logic [3:0][7:0] pinOe;
  logic [3:0][7:0] extDrive;
  logic [7:0] readData;
  logic [7:0] periphRdData;
  logic [2:0][7:0] inputCellOut;
  logic [31:0] seed = 32'h0001_41FC;
  logic [1:0] p;
  logic [7:0] d, dr, pt, ext, a, oe, lvl, ec;
  logic [7:0] dq [4];
  int failures = 0;
  int num_checks = 0;

  // Fixed setup: enable term on B3..0, logic outputs on A4, B7..6, C7, D2..1,
  // A high nibble latched on the strobe, B high nibble edge clocked by its term
  localparam logic [3:0][7:0] LO_CFG = 32'h0680_C010;
  localparam logic [7:0] GRP2_CFG = 8'h80;
  cio_ports #(
    .LOGIC_OUT(LO_CFG),
    .OE_PT_DEF(32'h0000_0F00),
    .B_GRP2(GRP2_CFG),
    .IC_MODE(12'h084),
    .IC_USE_PT(6'h08)
  ) u_dut (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .regWr(regWr),
    .rdReq(rdReq),
    .mcu(mcu),
    .arr(arr),
    .pinIn(pinIn),
    .pinOut(pinOut),
    .pinOe(pinOe),
    .readData(readData),
    .periphRdData(periphRdData),
    .inputCellOut(inputCellOut)
  );

  cio_pin_model u_pins (
    .pinOut(pinOut),
    .pinOe(pinOe),
    .extDrive(extDrive),
    .pinIn(pinIn)
  );

  // Repeatable xorshift source
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  // Pins present on each port
  function automatic logic [7:0] pmask(input logic [1:0] q);
    case (q)
      PORT_C: return C_USE_MASK;
      PORT_D: return D_MASK;
      default: return FULL_MASK;
    endcase
  endfunction

  // Output cell value routed to each port's pins
  function automatic logic [7:0] cexp(input logic [1:0] q);
    case (q)
      PORT_A: return arr.grp1;
      PORT_B: return (arr.grp2 & GRP2_CFG) | (arr.grp1 & ~GRP2_CFG);
      PORT_C: return arr.grp2 & C_USE_MASK;
      default: return {5'h00, arr.ecs, 1'b0};
    endcase
  endfunction

  // Pin value: logic outputs override the MCU side value
  function automatic logic [7:0] eo(input logic [1:0] q, input logic [7:0] v);
    return ((v & ~LO_CFG[q]) | (cexp(q) & LO_CFG[q])) & pmask(q);
  endfunction

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One register write, strobe held for a single edge
  task automatic wr(input logic [1:0] q, input logic [1:0] s, input logic [7:0] v);
    @(posedge ref_clk);
    regWr <= '{we: 1'b1, port: q, sel: s, data: v};
    @(posedge ref_clk);
    regWr.we <= 1'b0;
  endtask

  // Let registered and synchronised paths land
  task automatic settle();
    repeat (5) @(posedge ref_clk);
    #1;
  endtask

  task automatic rd(input logic [1:0] q, input cio_rb_t s, input logic [7:0] exp);
    @(posedge ref_clk);
    rdReq <= '{port: q, src: s};
    settle();
    check("readback", readData, exp);
  endtask

  // Clock
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    test_done();
  end

  // Main sequence
  initial
  begin
    resetn = 1'b0;
    regWr = '0;
    rdReq = '0;
    mcu = '0;
    arr = '0;
    extDrive = '0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    settle();
    for (int i = 0; i < 4; i++)
    begin
      check("enable at reset", pinOe[i], 8'h00);
      rd(i[1:0], RB_DIR, 8'h00);
      rd(i[1:0], RB_CTRL, 8'h00);
    end
    // Random data, direction, enable term and outside level on every port
    for (int i = 0; i < 12; i++)
    begin
      p = i[1:0];
      d = rnd();
      dr = rnd();
      wr(p, SEL_DOUT, d);
      wr(p, SEL_DIR, dr);
      dq[p] = d & pmask(p);
      pt = rnd();
      ext = rnd() & pmask(p);
      ec = rnd();
      @(posedge ref_clk);
      arr.oePt[p] <= pt;
      arr.grp1 <= rnd();
      arr.grp2 <= rnd();
      arr.ecs <= ec[1:0];
      extDrive[p] <= ext;
      settle();
      oe = ((pt & OE_PT_DEF_B(p)) | dr) & pmask(p);
      lvl = (oe & eo(p, d)) | (~oe & ext);
      check("pin enable", pinOe[p], oe);
      check("pin out", pinOut[p], eo(p, dq[p]));
      rd(p, RB_DIR, dr & pmask(p));
      rd(p, RB_DOUT, dq[p]);
      rd(p, RB_ENABLE, oe);
      rd(p, RB_DIN, lvl);
      rd(p, RB_CELL, cexp(p) & pmask(p));
      // High nibbles of A and B move only on their strobes, idle here
      if (i < 3)
        check("input cell", inputCellOut[p], lvl & (p[1] ? 8'hFF : 8'h0F));
    end
    // Input cells fed from outside: those pins kept as inputs
    wr(PORT_A, SEL_DIR, 8'h00);
    wr(PORT_B, SEL_DIR, 8'h00);
    a = rnd();
    d = rnd();
    @(posedge ref_clk);
    arr.oePt[1] <= 8'h00;
    extDrive[0] <= a;
    extDrive[1] <= d;
    mcu.ale <= 1'b1;
    settle();
    // Strobe drops on A, product term rises and stays high on B
    @(posedge ref_clk);
    mcu.ale <= 1'b0;
    arr.icPt[3] <= 1'b1;
    settle();
    @(posedge ref_clk);
    extDrive[0] <= ~a;
    extDrive[1] <= ~d;
    settle();
    check("latched cell", inputCellOut[0], {a[7:4], ~a[3:0]});
    check("edge cell", inputCellOut[1], {d[7:4], ~d[3:0]});
    rd(PORT_A, RB_INCELL, {a[7:4], ~a[3:0]});
    @(posedge ref_clk);
    arr.icPt[3] <= 1'b0;
    // Address out on ports A and B, then back to data out
    for (int i = 0; i < 2; i++)
    begin
      p = i[1:0];
      a = rnd();
      wr(p, SEL_DIR, 8'hFF);
      wr(p, SEL_CTRL, 8'hFF);
      @(posedge ref_clk);
      mcu.addr <= a;
      settle();
      check("address out", pinOut[p], eo(p, a));
      rd(p, RB_CTRL, 8'hFF);
      wr(p, SEL_CTRL, 8'h00);
      settle();
      check("data out again", pinOut[p], eo(p, dq[p]));
    end
    wr(PORT_C, SEL_CTRL, 8'hFF);
    rd(PORT_C, RB_CTRL, 8'h00);
    // Peripheral buffer; either select enables drive, gated in the block by mcu.wr
    a = rnd();
    ext = rnd();
    @(posedge ref_clk);
    mcu.memMap <= 8'h80;
    mcu.data <= a;
    mcu.wr <= 1'b1;
    arr.pselA <= 1'b0;
    arr.pselB <= 1'b0;
    extDrive[0] <= ext;
    settle();
    check("buffer idle", pinOe[0], 8'h00);
    check("peripheral read", periphRdData, ext);
    @(posedge ref_clk);
    arr.pselB <= 1'b1;
    settle();
    check("buffer driving", pinOe[0], 8'hFF);
    check("buffer data", pinOut[0], a);
    @(posedge ref_clk);
    arr.pselB <= 1'b0;
    arr.pselA <= 1'b1;
    settle();
    check("buffer other select", pinOe[0], 8'hFF);
    @(posedge ref_clk);
    mcu.wr <= 1'b0;
    settle();
    check("buffer on read", pinOe[0], 8'h00);
    check("peripheral read again", periphRdData, ext);
    test_done();
  end

  // Enable-term configuration of the instance, per port
  function automatic logic [7:0] OE_PT_DEF_B(input logic [1:0] q);
    return (q == PORT_B) ? 8'h0F : 8'h00;
  endfunction
endmodule
